/* File: src/wfbr_pkg.sv */
package wfbr_pkg;

  // register byte addresses
  localparam logic [31:0] WAKE_CTRL_ADDR   = 32'hB000_0218;
  localparam logic [31:0] WAKE_FLAGS_ADDR  = 32'hB000_021C;
  localparam logic [31:0] BLOCK_RST_ADDR   = 32'hB000_0220;
  localparam logic [31:0] INT_STATUS_ADDR  = 32'hB000_0230;
  localparam logic [31:0] INT_MASK_ADDR    = 32'hB000_0234;

  // wake control and flag fields
  localparam int          NUM_LINES        = 3;
  localparam int          WAKE_EN_LSB      = 0;
  localparam int          WAKE_POL_LSB     = 8;
  localparam int          WAKE_FLAGS_LSB   = 0;
  localparam logic [2:0]  WAKE_EN_RESET    = 3'h0;
  localparam logic [2:0]  WAKE_POL_RESET   = 3'h0;
  localparam logic [2:0]  WAKE_FLAGS_RESET = 3'h0;

  // block reset bit positions
  localparam int          I2C_RST_BIT      = 30;
  localparam int          SERIAL_IF_RST_BIT   = 29;
  localparam int          KEYPAD_RST_BIT      = 25;
  localparam int          TIMER_RST_BIT       = 19;
  localparam int          PWM_RST_BIT         = 18;
  localparam int          UART_RST_BIT        = 11;
  localparam int          GRAPHICS_RST_BIT    = 10;
  localparam int          USB_HOST_RST_BIT    = 9;
  localparam int          USB_DEV_RST_BIT     = 8;
  localparam int          ETH_MAC_RST_BIT     = 7;
  localparam int          HOST_XFER_RST_BIT   = 5;
  localparam int          FLASH_MEDIA_RST_BIT = 4;
  localparam int          GEN_XFER_RST_BIT    = 3;
  localparam int          AUDIO_RST_BIT       = 1;
  localparam int          DISPLAY_RST_BIT     = 0;
  localparam logic [31:0] BLOCK_RST_MASK   = 32'h6208_0FBB;
  localparam logic [31:0] BLOCK_RST_RESET  = 32'h0000_0000;

  // interrupt status: one bit per wake line, then reset-done
  localparam int          INT_W            = 4;
  localparam int          INT_RST_DONE_BIT = 3;
  localparam logic [3:0]  INT_STATUS_RESET = 4'h0;
  localparam logic [3:0]  INT_MASK_RESET   = 4'h0;

  // reset pulse width
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          RST_PULSE_NS     = 100;
  localparam int          RST_PULSE_CYC    = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_CNT_W        = 3;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_DOWN = 3'b010,
    ST_WAKE = 3'b100
  } wfbr_pwr_state_t;

endpackage : wfbr_pkg

/* File: src/wfbr_rst_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface wfbr_rst_if;
  logic        start;
  logic [31:0] start_bits;
  logic [31:0] pulse;
  logic        done;

  modport ctl (output start, output start_bits, input pulse, input done);
  modport gen (input start, input start_bits, output pulse, output done);
endinterface : wfbr_rst_if
`default_nettype wire

/* File: src/wfbr_pulse_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module wfbr_pulse_gen
  import wfbr_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  wfbr_rst_if.gen     rst
);

  logic [31:0]          pulse_reg;
  logic [RST_CNT_W-1:0] cnt_reg;
  logic                 done_reg;

  // a new start while pulsing adds its bits and restarts the width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= BLOCK_RST_RESET;
      cnt_reg   <= '0;
    end else if (rst.start && (rst.start_bits != 32'h0000_0000)) begin
      pulse_reg <= pulse_reg | rst.start_bits;
      cnt_reg   <= RST_CNT_W'(RST_PULSE_CYC - 1);
    end else if (pulse_reg != 32'h0000_0000) begin
      if (cnt_reg == '0) begin
        pulse_reg <= BLOCK_RST_RESET;
      end else begin
        cnt_reg <= cnt_reg - RST_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (pulse_reg != 32'h0000_0000) && (cnt_reg == '0) &&
                  !(rst.start && (rst.start_bits != 32'h0000_0000));
    end
  end

  assign rst.pulse = pulse_reg;
  assign rst.done  = done_reg;

endmodule : wfbr_pulse_gen
`default_nettype wire

/* File: src/wfbr_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1: three wake flags, one per interrupt line
// R2: software reads flags after power-down resume
// R3: software clears flags in interrupt routine
// R4: bit 30 write pulses both I2C resets
// R5: writing zero leaves controller untouched
// R6: reset bits clear themselves after pulse
// R7: bit 29 write resets universal serial controller
// R8: bit 25 write resets keypad scanner
// R9: bit 19 resets all timers and watchdog
// R10: bit 3 resets general transfer engine
// R11: bit 1 resets audio controller
// R12: bit 0 resets display panel controller
// R13: disabled line never wakes the chip
// R14: polarity bit picks high or low wake
// R15: software writes reserved bits as zero
// R16: flag set on wake, cleared by one
// R17: remaining reset bits pulse and self-clear likewise; PWM bit 18 is left out of BLOCK_RST_MASK and never pulses
module wfbr_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [wfbr_pkg::NUM_LINES-1:0] ext_interrupt_line_n,
  input  wire logic                         power_down_request,
  output logic                              wake_up,
  output logic      [31:0]                  block_reset_pulse,
  output logic                              irq
);
  import wfbr_pkg::*;

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // level on the pin matches polarity on an enabled line
  function automatic logic [NUM_LINES-1:0] wake_hits(
    input logic [NUM_LINES-1:0] lines,
    input logic [NUM_LINES-1:0] en,
    input logic [NUM_LINES-1:0] pol
  );
    wake_hits = en & ~(lines ^ pol);
  endfunction : wake_hits

  function automatic logic addr_mapped(input logic [31:0] a);
    if (a == WAKE_CTRL_ADDR) begin
      addr_mapped = 1'b1;
    end else if (a == WAKE_FLAGS_ADDR) begin
      addr_mapped = 1'b1;
    end else if (a == BLOCK_RST_ADDR) begin
      addr_mapped = 1'b1;
    end else if (a == INT_STATUS_ADDR) begin
      addr_mapped = 1'b1;
    end else if (a == INT_MASK_ADDR) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction : addr_mapped

  wfbr_pwr_state_t      state_reg;
  wfbr_pwr_state_t      state_next;
  logic [NUM_LINES-1:0] wake_en_reg;
  logic [NUM_LINES-1:0] wake_pol_reg;
  logic [NUM_LINES-1:0] wake_flags_reg;
  logic [NUM_LINES-1:0] wake_flags_next;
  logic [INT_W-1:0]     int_status_reg;
  logic [INT_W-1:0]     int_status_next;
  logic [INT_W-1:0]     int_mask_reg;
  logic [INT_W-1:0]     int_mask_next;
  logic [31:0]          prdata_reg;
  logic                 wake_up_reg;
  logic                 irq_reg;
  logic                 setup_phase;
  logic                 access_wr;
  logic                 access_rd;
  logic [31:0]          wr_lanes;
  logic [NUM_LINES-1:0] hits;
  logic                 wake_event;
  logic                 rst_start;

  wfbr_rst_if rst_bus ();

  wfbr_pulse_gen u_pulse_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .rst     (rst_bus.gen)
  );

  // zero-wait slave: every access completes on its first access cycle
  assign setup_phase = psel && !penable;
  assign access_wr   = psel && penable && pwrite;
  assign access_rd   = psel && penable && !pwrite;
  assign wr_lanes    = pwdata & lane_mask(pstrb);
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !addr_mapped(paddr);
  assign prdata      = prdata_reg;

  // read data staged during setup so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      if (paddr == WAKE_CTRL_ADDR) begin
        prdata_reg <= (32'(wake_pol_reg) << WAKE_POL_LSB) | (32'(wake_en_reg) << WAKE_EN_LSB);
      end else if (paddr == WAKE_FLAGS_ADDR) begin
        prdata_reg <= 32'(wake_flags_reg) << WAKE_FLAGS_LSB; // [R1]
      end else if (paddr == INT_STATUS_ADDR) begin
        prdata_reg <= 32'(int_status_reg);
      end else if (paddr == INT_MASK_ADDR) begin
        prdata_reg <= 32'(int_mask_reg);
      end else begin
        // reset register is write-only and reads zero, like holes
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // wake enable and polarity; reserved bits are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en_reg  <= WAKE_EN_RESET;
      wake_pol_reg <= WAKE_POL_RESET;
    end else if (access_wr && (paddr == WAKE_CTRL_ADDR)) begin
      if (pstrb[0]) begin
        wake_en_reg <= pwdata[WAKE_EN_LSB +: NUM_LINES];
      end
      if (pstrb[1]) begin
        wake_pol_reg <= pwdata[WAKE_POL_LSB +: NUM_LINES];
      end
    end
  end

  // power-down tracking: only a line seen while down counts as a wake
  assign hits       = wake_hits(ext_interrupt_line_n, wake_en_reg, wake_pol_reg); // [R13] [R14]
  assign wake_event = (state_reg == ST_DOWN) && (hits != '0);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (power_down_request) begin
          state_next = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (hits != '0) begin
          state_next = ST_WAKE;
        end else if (!power_down_request) begin
          state_next = ST_RUN;
        end
      end
      ST_WAKE: begin
        if (!power_down_request) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_up_reg <= 1'b0;
    end else begin
      wake_up_reg <= wake_event;
    end
  end

  assign wake_up = wake_up_reg;

  // write one clears; a wake in the same cycle still wins
  always_comb begin
    wake_flags_next = wake_flags_reg;
    if (access_wr && (paddr == WAKE_FLAGS_ADDR)) begin
      wake_flags_next = wake_flags_next & ~wr_lanes[WAKE_FLAGS_LSB +: NUM_LINES]; // [R16]
    end
    if (wake_event) begin
      wake_flags_next = wake_flags_next | hits; // [R16] [R1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_flags_reg <= WAKE_FLAGS_RESET;
    end else begin
      wake_flags_reg <= wake_flags_next;
    end
  end

  // only implemented ones start pulses; zeros and reserved bits do nothing
  assign rst_start              = access_wr && (paddr == BLOCK_RST_ADDR);
  assign rst_bus.start          = rst_start; // [R5]
  assign rst_bus.start_bits     = wr_lanes & BLOCK_RST_MASK; // [R4] [R7] [R8] [R9] [R10] [R11] [R12] [R17]
  // the pulse counter alone clears the bits, so nothing is stored to read back
  assign block_reset_pulse      = rst_bus.pulse; // [R6]

  // interrupt status clears on read; an event in that cycle survives
  // only bits already returned are cleared, so an event after setup stays
  always_comb begin
    int_status_next = int_status_reg;
    if (access_rd && (paddr == INT_STATUS_ADDR)) begin
      int_status_next = int_status_next & ~prdata_reg[INT_W-1:0];
    end
    if (wake_event) begin
      int_status_next[NUM_LINES-1:0] = int_status_next[NUM_LINES-1:0] | hits;
    end
    if (rst_bus.done) begin
      int_status_next[INT_RST_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= INT_STATUS_RESET;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= INT_MASK_RESET;
    end else begin
      int_mask_reg <= int_mask_next;
    end
  end

  // irq looks ahead at the mask too, so a mask write never leaves it one cycle stale
  assign int_mask_next = (access_wr && (paddr == INT_MASK_ADDR) && pstrb[0]) ?
                         pwdata[INT_W-1:0] : int_mask_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (int_status_next & int_mask_next) != '0;
    end
  end

  assign irq = irq_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_serial_start;
    rst_start && pwdata[SERIAL_IF_RST_BIT] && pstrb[3];
  endsequence

  sequence s_quiet4;
    (!rst_start) [*4];
  endsequence

  property p_flag_on_wake;
    (state_reg == ST_DOWN) && hits[0] |=> wake_flags_reg[0] && wake_up;
  endproperty
  a_flag_on_wake: assert property (p_flag_on_wake) else $error("wake flag not set"); // [R16]

  property p_flag_holds;
    !wake_event && !(access_wr && (paddr == WAKE_FLAGS_ADDR)) |=> $stable(wake_flags_reg);
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("wake flag moved"); // [R1]

  property p_enable_gates;
    !wake_en_reg[1] && !wake_flags_reg[1] |=> !wake_flags_reg[1];
  endproperty
  a_enable_gates: assert property (p_enable_gates) else $error("disabled line woke"); // [R13]

  property p_polarity;
    (state_reg == ST_DOWN) && wake_en_reg[2] && (ext_interrupt_line_n[2] == wake_pol_reg[2])
      |=> wake_flags_reg[2] ##1 wake_flags_reg[2] || $past(access_wr);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wake missed"); // [R14]

  property p_zero_write;
    rst_start && (wr_lanes == 32'h0000_0000) && (block_reset_pulse == 32'h0000_0000)
      |=> block_reset_pulse == 32'h0000_0000;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write pulsed"); // [R5]

  property p_i2c_pulse;
    rst_start && pwdata[I2C_RST_BIT] && pstrb[3] |=> block_reset_pulse[I2C_RST_BIT] [*4];
  endproperty
  a_i2c_pulse: assert property (p_i2c_pulse) else $error("i2c reset too short"); // [R4]

  property p_timer_pulse;
    rst_start && pwdata[TIMER_RST_BIT] && pstrb[2] |=> block_reset_pulse[TIMER_RST_BIT];
  endproperty
  a_timer_pulse: assert property (p_timer_pulse) else $error("timer reset missing"); // [R9]

  property p_serial_selfclear;
    s_serial_start ##1 s_quiet4 |=> !block_reset_pulse[SERIAL_IF_RST_BIT];
  endproperty
  a_serial_selfclear: assert property (p_serial_selfclear) else $error("serial reset stuck"); // [R6] [R7]

  property p_lcd_only;
    rst_start && (wr_lanes == 32'h0000_0001) && (block_reset_pulse == 32'h0000_0000)
      |=> block_reset_pulse == 32'h0000_0001;
  endproperty
  a_lcd_only: assert property (p_lcd_only) else $error("display reset wrong"); // [R12]

  property p_reserved_quiet;
    (block_reset_pulse & ~BLOCK_RST_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved pulse"); // [R17]

  property p_irq_level;
    ##1 (irq == ((int_status_reg & int_mask_reg) != '0));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_flag_clear;
    access_wr && (paddr == WAKE_FLAGS_ADDR) && pwdata[0] && pstrb[0] && !hits[0]
      |=> !wake_flags_reg[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("wake flag not cleared"); // [R16]

  property p_done_status;
    (block_reset_pulse != 32'h0000_0000) ##1 (block_reset_pulse == 32'h0000_0000)
      |=> int_status_reg[INT_RST_DONE_BIT];
  endproperty
  a_done_status: assert property (p_done_status) else $error("reset done not flagged"); // [R6]

  property p_wake_status;
    wake_event |=> (int_status_reg[NUM_LINES-1:0] & $past(hits)) == $past(hits);
  endproperty
  a_wake_status: assert property (p_wake_status) else $error("wake status not set");

endmodule : wfbr_top
`default_nettype wire

/* File: dv/wfbr_periph_model.sv */
`timescale 1ns/10ps
`default_nettype none
module wfbr_periph_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [31:0] block_reset_pulse
);
  // width is logged only when a pulse ends, so a stuck pulse never counts
  int unsigned run_len [32];
  int unsigned width   [32];
  int unsigned count   [32];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 32; b++) begin
        run_len[b] <= 0;
        width[b]   <= 0;
        count[b]   <= 0;
      end
    end else begin
      for (int b = 0; b < 32; b++) begin
        if (block_reset_pulse[b]) begin
          run_len[b] <= run_len[b] + 1;
        end else if (run_len[b] != 0) begin
          width[b]   <= run_len[b];
          count[b]   <= count[b] + 1;
          run_len[b] <= 0;
        end
      end
    end
  end
endmodule : wfbr_periph_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wfbr_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  lines_n;
  logic        sleep_req;
  logic [3:0]  strb;
  logic        wake_up;
  logic [31:0] block_reset_pulse;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          samples_checked;

  wfbr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_interrupt_line_n(lines_n),
    .power_down_request(sleep_req), .wake_up(wake_up),
    .block_reset_pulse(block_reset_pulse), .irq(irq));

  wfbr_periph_model periph (.pclk(pclk), .presetn(presetn),
    .block_reset_pulse(block_reset_pulse));

  always #12.5 pclk = ~pclk;

  task automatic complete_run();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic expire(input string what);
    fail_count++;
    $display("[FAIL] %0t %s timed out", $time, what);
    complete_run();
  endtask : expire

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) expire("bus");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic int unsigned total();
    int unsigned s = 0;
    for (int b = 0; b < 32; b++) s += periph.count[b];
    return s;
  endfunction : total

  task automatic t_bus();
    apb(1'b0, WAKE_FLAGS_ADDR, 32'h0);
    chk(rd, 32'h0, "flags after reset");
    apb(1'b0, BLOCK_RST_ADDR, 32'h0);
    chk(rd, 32'h0, "reset reg after reset");
    apb(1'b0, 32'hB000_0200, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test bus done");
  endtask : t_bus

  // quiet: levels that must not wake; hit: the waking level
  task automatic t_wake(input logic [31:0] ctrl, input logic [2:0] quiet,
                        input logic [2:0] hit, input logic [2:0] flag, input logic [3:0] mask);
    int n;
    int hits;
    apb(1'b1, INT_MASK_ADDR, {28'h0, mask});
    apb(1'b1, WAKE_CTRL_ADDR, ctrl);
    lines_n <= quiet;
    repeat (4) @(posedge pclk);
    sleep_req <= 1'b1;
    hits = 0;
    repeat (12) begin
      @(posedge pclk);
      if (wake_up === 1'b1) hits++;
    end
    chk(32'(hits), 32'h0, "wake on quiet lines");
    lines_n <= hit;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (wake_up === 1'b1) break;
    end
    if (n == 20) expire("wake");
    sleep_req <= 1'b0;
    lines_n <= 3'h7;
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, |(mask[2:0] & flag)}, "irq after wake");
    apb(1'b0, WAKE_FLAGS_ADDR, 32'h0);
    chk(rd, {29'h0, flag}, "flag of waking line");
    apb(1'b1, WAKE_FLAGS_ADDR, 32'h0);
    apb(1'b0, WAKE_FLAGS_ADDR, 32'h0);
    chk(rd, {29'h0, flag}, "flag held on write 0");
    apb(1'b1, WAKE_FLAGS_ADDR, {29'h0, flag});
    apb(1'b0, WAKE_FLAGS_ADDR, 32'h0);
    chk(rd, 32'h0, "flag cleared by write 1");
    apb(1'b0, INT_STATUS_ADDR, 32'h0);
    chk(rd, {29'h0, flag}, "wake status");
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq after status read");
    $display("test wake %h done", flag);
  endtask : t_wake

  task automatic t_resets();
    int unsigned exp;
    apb(1'b1, BLOCK_RST_ADDR, 32'h0);
    repeat (8) @(posedge pclk);
    chk(total(), 32'h0, "pulse after write 0");
    strb <= 4'h7;
    apb(1'b1, BLOCK_RST_ADDR, 32'h4000_0000);
    strb <= 4'hF;
    repeat (8) @(posedge pclk);
    chk(total(), 32'h0, "pulse from unstrobed lane");
    exp = 0;
    for (int b = 0; b < 32; b++) begin
      if (BLOCK_RST_MASK[b]) begin
        apb(1'b1, BLOCK_RST_ADDR, 32'h1 << b);
        repeat (8) @(posedge pclk);
        exp++;
        chk(periph.count[b], 32'h1, "one pulse");
        chk(periph.width[b], 32'(RST_PULSE_CYC), "pulse width");
        chk(total(), exp, "only the written bit pulsed");
        apb(1'b0, BLOCK_RST_ADDR, 32'h0);
        chk(rd, 32'h0, "bit cleared itself");
      end
    end
    apb(1'b0, INT_STATUS_ADDR, 32'h0);
    chk(rd, 32'h8, "reset done status");
    $display("test resets done");
  endtask : t_resets

  initial begin
    pclk            = 1'b0;
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 32'h0;
    pwdata          = 32'h0;
    lines_n         = 3'h7;
    sleep_req       = 1'b0;
    strb            = 4'hF;
    fail_count      = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_wake(32'h0000_0101, 3'h0, 3'h1, 3'h1, 4'h0);
    t_wake(32'h0000_0006, 3'h6, 3'h2, 3'h4, 4'h4);
    t_resets();
    complete_run();
  end
endmodule : tb
`default_nettype wire
